// ==== wdr_top.sv ====
// watchdog register block: register port, start, reload slots, timeout event and reset request
// assumes synchronous register strobes, read data one cycle after the read strobe
`timescale 1ns/10ps
module wdr_top
  import wdr_pkg::*;
#(
  parameter int DIV   = TICK_DIV,
  parameter int SLOTS = NUM_SLOTS
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // register port
  input  wire logic [11:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // system outputs
  output logic             irq,
  output logic             wdog_reset,
  output logic             timeout_pulse
);
  // ****************************************************************
  // decode
  // ****************************************************************
  logic              run_q;
  logic              ien_q;
  logic              tevt_q;
  logic [31:0]       reload_q;
  logic [SLOTS-1:0]  slot_en_q;
  logic [SLOTS-1:0]  keyed_q;
  logic [1:0]        istat_q;
  logic [1:0]        imask_q;
  logic              rst_pend_q;
  logic [1:0]        rst_cnt_q;
  logic              tick;
  logic              wrap;
  logic [SLOTS-1:0]  slot_hit;
  localparam int     IDX_W = $clog2(SLOTS);

  wire        w_start   = wr && addr == OFF_START && wdata[0];
  wire        w_tevt    = wr && addr == OFF_TIMEOUT;
  wire        w_iset    = wr && addr == OFF_IRQ_SET && wdata[0];
  wire        w_iclr    = wr && addr == OFF_IRQ_CLR && wdata[0];
  wire        w_reload  = wr && addr == OFF_RELOAD && !run_q;
  wire        w_slot_en = wr && addr == OFF_SLOT_EN && !run_q;
  // only the exact key counts; any other value leaves the slot pending
  wire        w_slot    = wr && addr >= OFF_SLOT0 && addr <= OFF_SLOT_END && wdata == RELOAD_KEY;
  wire [IDX_W-1:0] slot_idx = addr[SLOT_SEL_LSB +: IDX_W];
  wire        w_istat   = wr && addr == OFF_IRQ_STAT;
  wire        w_imask   = wr && addr == OFF_IRQ_MASK;
  wire        do_start  = w_start && !run_q;
  // reload fires once every enabled slot holds the key
  wire [SLOTS-1:0] keyed_next = keyed_q | slot_hit;
  wire        all_keyed = run_q && ((keyed_next & slot_en_q) == slot_en_q);
  wire        do_reload = all_keyed && w_slot;
  wire [SLOTS-1:0] pending = slot_en_q & ~keyed_q;

  // ****************************************************************
  // counter and tick
  // ****************************************************************
  wdr_tick #(.DIV(DIV)) u_tick (
    .clk    (clk),
    .arst_n (arst_n),
    .tick   (tick)
  );

  wdr_counter u_cnt (
    .clk        (clk),
    .arst_n     (arst_n),
    .tick       (tick),
    .load       (do_start || do_reload),
    .run        (run_q),
    .reload_val (reload_q),
    .wrap       (wrap)
  );

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run_q <= 1'b0;
    end else if (do_start) begin
      run_q <= 1'b1;
    end
  end

  // reload value and slot enable writes are dropped once running, so a runaway program cannot stretch the timeout
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reload_q <= RELOAD_RST;
    end else if (w_reload) begin
      reload_q <= wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      slot_en_q <= SLOTS'(SLOT_EN_RST);
    end else if (w_slot_en) begin
      slot_en_q <= wdata[SLOTS-1:0];
    end
  end

  // ****************************************************************
  // reload request slots, interrupt enable, timeout flag, status and mask
  // ****************************************************************
  // one key latch per slot; a finished reload or a fresh start re-arms them all
  for (genvar g = 0; g < SLOTS; g++) begin : g_slot
    logic key_q;
    assign slot_hit[g] = w_slot && slot_idx == IDX_W'(g);
    assign keyed_q[g]  = key_q;
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        key_q <= 1'b0;
      end else if (do_reload || do_start) begin
        key_q <= 1'b0;
      end else if (slot_hit[g]) begin
        key_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ien_q <= 1'b0;
    end else if (w_iset) begin
      ien_q <= 1'b1;
    end else if (w_iclr) begin
      ien_q <= 1'b0;
    end
  end

  // set wins over a software clear in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tevt_q <= 1'b0;
    end else if (wrap) begin
      tevt_q <= 1'b1;
    end else if (w_tevt) begin
      tevt_q <= wdata[0];
    end
  end

  // bit 0 marks every timeout, bit 1 only those whose reset is being held back
  wire [1:0] ev = ({2{wrap}} & IRQ_TIMEOUT_BIT) | ({2{wrap && ien_q}} & IRQ_RESET_BIT);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      istat_q <= 2'h0;
    end else begin
      istat_q <= (istat_q & ~({2{w_istat}} & wdata[1:0])) | ev;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      imask_q <= 2'h0;
    end else if (w_imask) begin
      imask_q <= wdata[1:0];
    end
  end

  // ****************************************************************
  // watchdog reset
  // ****************************************************************
  // once pending the reset cannot be withdrawn, and a further wrap does not restart the delay
  wire rst_arm  = wrap && ien_q && !rst_pend_q;
  wire rst_last = rst_pend_q && tick && rst_cnt_q == 2'h1;
  wire rst_fire = (wrap && !ien_q) || rst_last;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_pend_q <= 1'b0;
      rst_cnt_q  <= 2'h0;
    end else if (rst_arm) begin
      rst_pend_q <= 1'b1;
      rst_cnt_q  <= 2'(RST_DELAY_TICKS);
    end else if (rst_pend_q && tick) begin
      rst_pend_q <= !rst_last;
      rst_cnt_q  <= rst_cnt_q - 2'h1;
    end
  end

  // sticky: only a reset of this block takes the request away
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wdog_reset <= 1'b0;
    end else if (rst_fire) begin
      wdog_reset <= 1'b1;
    end
  end

  // ****************************************************************
  // read path and outputs
  // ****************************************************************
  // unmapped offsets and the write-only slots read as zero
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h00000000;
    unique case (addr)
      OFF_TIMEOUT:  rmux[0] = tevt_q;
      OFF_IRQ_SET,
      OFF_IRQ_CLR:  rmux[0] = ien_q;
      OFF_RUN:      rmux[0] = run_q;
      OFF_PENDING:  rmux[SLOTS-1:0] = pending;
      OFF_RELOAD:   rmux = reload_q;
      OFF_SLOT_EN:  rmux[SLOTS-1:0] = slot_en_q;
      OFF_IRQ_STAT: rmux[1:0] = istat_q;
      OFF_IRQ_MASK: rmux[1:0] = imask_q;
      default:      rmux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 32'h00000000;
    end else begin
      rdata <= rd ? rmux : 32'h00000000;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(istat_q & imask_q);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timeout_pulse <= 1'b0;
    end else begin
      timeout_pulse <= wrap;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_start_runs: assert property (@(posedge clk) disable iff (!arst_n)
    do_start |=> run_q) else $error("start did not set run");
  a_cfg_locked: assert property (@(posedge clk) disable iff (!arst_n)
    run_q && wr && addr == OFF_RELOAD |=> $stable(reload_q)) else $error("reload value changed while running");
  a_ien_set: assert property (@(posedge clk) disable iff (!arst_n)
    w_iset |=> ien_q) else $error("enable set failed");
  a_ien_clr: assert property (@(posedge clk) disable iff (!arst_n)
    w_iclr && !w_iset |=> !ien_q) else $error("enable clear failed");
  a_wrap_event: assert property (@(posedge clk) disable iff (!arst_n)
    wrap |=> tevt_q) else $error("timeout flag not raised");
  a_reset_now: assert property (@(posedge clk) disable iff (!arst_n)
    wrap && !ien_q |=> wdog_reset) else $error("immediate reset missing");
  a_reset_late: assert property (@(posedge clk) disable iff (!arst_n)
    wrap && ien_q && !wdog_reset |=> !wdog_reset) else $error("delayed reset came early");
  a_pend_map: assert property (@(posedge clk) disable iff (!arst_n)
    do_reload |=> pending == slot_en_q) else $error("slots not re-armed");
  a_slot_rst: assert property (@(posedge clk) disable iff (!arst_n)
    !run_q && w_slot_en |=> slot_en_q == $past(wdata[SLOTS-1:0])) else $error("slot enable write lost");
  a_reset_sticky: assert property (@(posedge clk) disable iff (!arst_n)
    wdog_reset |=> wdog_reset) else $error("watchdog reset withdrawn");
  a_delay_fires: assert property (@(posedge clk) disable iff (!arst_n)
    rst_last |=> wdog_reset) else $error("delayed reset never came");
  a_rst_armed: assert property (@(posedge clk) disable iff (!arst_n)
    rst_arm |=> rst_pend_q) else $error("delayed reset not armed");
  a_run_stays: assert property (@(posedge clk) disable iff (!arst_n)
    run_q |=> run_q) else $error("run indicator dropped");
  a_slot_locked: assert property (@(posedge clk) disable iff (!arst_n)
    run_q && wr && addr == OFF_SLOT_EN |=> $stable(slot_en_q)) else $error("slot enables changed while running");
  a_key_taken: assert property (@(posedge clk) disable iff (!arst_n)
    w_slot && run_q && !do_reload |=> !pending[$past(slot_idx)]) else $error("key did not clear pending bit");
  a_start_rearm: assert property (@(posedge clk) disable iff (!arst_n)
    do_start |=> pending == slot_en_q) else $error("start did not arm slots");
  a_wrap_pulse: assert property (@(posedge clk) disable iff (!arst_n)
    wrap |=> timeout_pulse) else $error("timeout pulse missing");
  a_pulse_single: assert property (@(posedge clk) disable iff (!arst_n)
    timeout_pulse |=> !timeout_pulse) else $error("timeout pulse too long");
  a_flag_set: assert property (@(posedge clk) disable iff (!arst_n)
    wrap |=> (istat_q & IRQ_TIMEOUT_BIT) != 2'h0) else $error("timeout status bit not set");
  a_flag_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !wrap && !w_tevt |=> $stable(tevt_q)) else $error("timeout flag changed by itself");
  a_delay_flag: assert property (@(posedge clk) disable iff (!arst_n)
    wrap && ien_q |=> (istat_q & IRQ_RESET_BIT) != 2'h0) else $error("delayed reset status bit not set");
  a_ien_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !w_iset && !w_iclr |=> $stable(ien_q)) else $error("interrupt enable changed by itself");
  a_rdata_idle: assert property (@(posedge clk) disable iff (!arst_n)
    !rd |=> rdata == 32'h00000000) else $error("read data not idle");
  a_irq_masked: assert property (@(posedge clk) disable iff (!arst_n)
    imask_q == 2'h0 |=> !irq) else $error("masked interrupt raised");
  a_irq_level: assert property (@(posedge clk) disable iff (!arst_n)
    (istat_q & imask_q) != 2'h0 |=> irq) else $error("unmasked interrupt missing");
endmodule

// ==== wdr_pkg.sv ====
// package for the watchdog register block: register offsets, reset values, key, timing
// assumes a 32-bit plain register port and a 200 MHz core clock
package wdr_pkg;
  localparam logic [11:0] OFF_START    = 12'h000;
  localparam logic [11:0] OFF_TIMEOUT  = 12'h100;
  localparam logic [11:0] OFF_IRQ_SET  = 12'h304;
  localparam logic [11:0] OFF_IRQ_CLR  = 12'h308;
  localparam logic [11:0] OFF_RUN      = 12'h400;
  localparam logic [11:0] OFF_PENDING  = 12'h404;
  localparam logic [11:0] OFF_RELOAD   = 12'h504;
  localparam logic [11:0] OFF_SLOT_EN  = 12'h508;
  localparam logic [11:0] OFF_SLOT0    = 12'h600;
  localparam logic [11:0] OFF_SLOT_END = 12'h61C;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h700;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h704;
  localparam int          SLOT_SEL_LSB = 2;
  localparam int          NUM_SLOTS    = 8;
  localparam logic [31:0] RELOAD_RST   = 32'hFFFFFFFF;
  localparam logic [7:0]  SLOT_EN_RST  = 8'h01;
  localparam logic [31:0] RELOAD_KEY   = 32'h6E524635;
  localparam int          TICK_DIV     = 6104;
  localparam int          RST_DELAY_TICKS = 2;
  localparam logic [1:0]  IRQ_TIMEOUT_BIT = 2'h1;
  localparam logic [1:0]  IRQ_RESET_BIT   = 2'h2;
endpackage

// ==== wdr_tick.sv ====
// low-frequency tick generator: one-cycle pulse per 32.768 kHz period
// assumes a free running core clock
`timescale 1ns/10ps
module wdr_tick
  import wdr_pkg::*;
#(
  parameter int DIV = TICK_DIV
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // tick out
  output logic      tick
);
  logic [15:0] cnt_q;
  wire         wrap = (cnt_q == 16'(DIV - 1));
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b0;
    end else begin
      cnt_q <= wrap ? 16'h0000 : cnt_q + 16'h0001;
      tick  <= wrap;
    end
  end
endmodule

// ==== wdr_counter.sv ====
// watchdog down-counter on the low-frequency tick
// assumes tick is a one-cycle pulse in the core domain
`timescale 1ns/10ps
module wdr_counter (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // control
  input  wire logic        tick,
  input  wire logic        load,
  input  wire logic        run,
  input  wire logic [31:0] reload_val,
  // status
  output logic             wrap
);
  logic [31:0] cnt_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 32'h00000000;
      wrap  <= 1'b0;
    end else begin
      wrap <= 1'b0;
      if (load) begin
        cnt_q <= reload_val;
      end else if (run && tick) begin
        // wrap past zero reloads so the period is reload value plus one
        if (cnt_q == 32'h00000000) begin
          cnt_q <= reload_val;
          wrap  <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 32'h00000001;
        end
      end
    end
  end
endmodule

// ==== test_watchdog_register_interface.sv ====
// self-checking bench for the watchdog register block: register table rows, start lock, reload slots, timeout
// assumes wdr_top with a shortened tick divider and the plain one-cycle register port
`timescale 1ns/10ps
module test_watchdog_register_interface
  import wdr_pkg::*;
();
  // ********************************
  // signals
  // ********************************
  localparam int DV = 4;
  typedef struct packed {
    logic        w;
    logic [11:0] wa;
    logic [31:0] wd;
    logic [11:0] ra;
    logic [31:0] exp;
  } wdr_row_t;
  logic        clk;
  logic        arst_n;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        irq;
  logic        wdog_reset;
  logic        timeout_pulse;
  int          miscompares = 0;
  int          num_checks  = 0;
  int          cycles      = 0;
  int          k;
  wdr_row_t    rows [11];

  wdr_top #(.DIV(DV), .SLOTS(NUM_SLOTS)) i_dut (
    .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .irq(irq), .wdog_reset(wdog_reset), .timeout_pulse(timeout_pulse)
  );

  // ********************************
  // tasks
  // ********************************
  task automatic end_sim;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rreg(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), e, rdata);
  endtask

  task automatic wait_for(input bit rst_sel, input int mx, output int n);
    n = 0;
    while ((rst_sel ? wdog_reset : timeout_pulse) !== 1'b1 && n < mx) begin
      @(posedge clk);
      #1 n++;
    end
  endtask

  task automatic do_reset;
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
  endtask

  // ********************************
  // clock and hang guard
  // ********************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      end_sim;
    end
  end

  // ********************************
  // sequence
  // ********************************
  initial begin
    arst_n = 1'b0;
    wr     = 1'b0;
    rd     = 1'b0;
    addr   = 12'h000;
    wdata  = 32'h0;
    rows = '{
      '{1'b0, 12'h000, 32'h0, OFF_RUN, 32'h0},
      '{1'b0, 12'h000, 32'h0, OFF_RELOAD, RELOAD_RST},
      '{1'b0, 12'h000, 32'h0, OFF_SLOT_EN, 32'h1},
      '{1'b0, 12'h000, 32'h0, OFF_PENDING, 32'h1},
      '{1'b0, 12'h000, 32'h0, OFF_IRQ_SET, 32'h0},
      '{1'b0, 12'h000, 32'h0, 12'h7F0, 32'h0},
      '{1'b1, OFF_IRQ_SET, 32'h1, OFF_IRQ_SET, 32'h1},
      '{1'b0, 12'h000, 32'h0, OFF_IRQ_CLR, 32'h1},
      '{1'b1, OFF_IRQ_CLR, 32'h1, OFF_IRQ_CLR, 32'h0},
      '{1'b1, OFF_RELOAD, 32'hF, OFF_RELOAD, 32'hF},
      '{1'b1, OFF_SLOT_EN, 32'h3, OFF_PENDING, 32'h3}
    };
    do_reset;
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wreg(rows[i].wa, rows[i].wd);
      end
      rreg(rows[i].ra, rows[i].exp);
    end
    wreg(OFF_IRQ_SET, 32'h1);
    wreg(OFF_START, 32'h1);
    rreg(OFF_RUN, 32'h1);
    wreg(OFF_RELOAD, 32'h7);
    rreg(OFF_RELOAD, 32'hF);
    wreg(OFF_SLOT_EN, 32'hFF);
    rreg(OFF_SLOT_EN, 32'h3);
    wreg(OFF_SLOT0, RELOAD_KEY);
    rreg(OFF_PENDING, 32'h2);
    wreg(OFF_SLOT0 + 12'h004, 32'h6E524634);
    rreg(OFF_PENDING, 32'h2);
    wreg(OFF_SLOT0 + 12'h004, RELOAD_KEY);
    // without the reload the wrap would come some 20 cycles early
    wait_for(1'b0, 100, k);
    chk("reload to wrap", 32'h1, 32'(k >= 15 * DV - 1 && k <= 16 * DV + 2));
    chk("reset at wrap", 32'h0, 32'(wdog_reset));
    wait_for(1'b1, 30, k);
    chk("delayed reset", 32'h1, 32'(k >= 2 * DV - 2 && k <= 2 * DV + 2 && wdog_reset === 1'b1));
    chk("irq masked", 32'h0, 32'(irq));
    wreg(OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk);
    #1 chk("irq unmasked", 32'h1, 32'(irq));
    rreg(OFF_TIMEOUT, 32'h1);
    wreg(OFF_IRQ_STAT, 32'h3);
    repeat (2) @(posedge clk);
    #1 chk("irq cleared", 32'h0, 32'(irq));
    do_reset;
    #1 chk("reset cleared", 32'h0, {30'h0, irq, wdog_reset});
    rreg(OFF_RUN, 32'h0);
    wreg(OFF_RELOAD, 32'h5);
    wreg(OFF_START, 32'h1);
    wait_for(1'b0, 60, k);
    chk("start to wrap", 32'h1, 32'(k >= 6 * DV - 2 && k <= 6 * DV + 1));
    wait_for(1'b1, 2, k);
    chk("direct reset", 32'h1, 32'(wdog_reset === 1'b1 && k == 0));
    @(posedge clk);
    #1 chk("pulse one cycle", 32'h0, 32'(timeout_pulse));
    rreg(OFF_TIMEOUT, 32'h1);
    wreg(OFF_TIMEOUT, 32'h0);
    rreg(OFF_TIMEOUT, 32'h0);
    end_sim;
  end
endmodule
